// File: logic/nld_pkg.sv
package nld_pkg;
// How it works
// - once power lockdown is set, only a power cycle clears it
// - under lockdown, protection field writes are dropped
// - a feature write to B0h with the lockdown bit set engages it
// - correction is on after power-up
// - feature write 1Fh sets or clears the correction-on bit
// - with correction on, parity is computed before a page commit
// - with correction on, reads check and fix the cache before output
// - each checked read updates the correction status field
// - page is four 512B main, four 16B meta and parity segments
// - with correction on, writes to 840h-87Fh are discarded
// - with correction off, every page byte is open to the host
// - only the sleep opcode enters deep sleep; deselect gives standby when awake and not busy
// - sleep runs only if select rises right after eight opcode bits
// - deep sleep begins once the sleep entry delay has elapsed
// - in deep sleep only release, soft reset and reset pair act
// - sleep during an array operation is rejected without effect
// - release leaves deep sleep; feature reads are taken at once, other commands after the wake delay
// - release while busy is ignored
// - reset pair ends deep sleep and restores power-on features except lockdown and a frozen protection field
// - deep sleep never survives power loss; power-up is standby

   // opcodes
   localparam logic [7:0] OP_FEAT_WR  = 8'h1f;
   localparam logic [7:0] OP_FEAT_RD  = 8'h0f;
   localparam logic [7:0] OP_SLEEP    = 8'hb9;
   localparam logic [7:0] OP_RELEASE  = 8'hab;
   localparam logic [7:0] OP_SOFT_RST = 8'hff;
   localparam logic [7:0] OP_RST_EN   = 8'h66;
   localparam logic [7:0] OP_RST      = 8'h99;

   // feature addresses and bit positions
   localparam logic [7:0] FA_PROT = 8'ha0;
   localparam logic [7:0] FA_CFG  = 8'hb0;
   localparam logic [7:0] FA_STAT = 8'hc0;
   localparam int PB_GUARD    = 7;
   localparam int PB_LOCK_HI  = 5;
   localparam int PB_LOCK_LO  = 3;
   localparam int PB_FLIP     = 2;
   localparam int PB_COMP     = 1;
   localparam int CB_ECC      = 4;
   localparam int CB_LOCKDOWN = 1;
   localparam int CB_QE       = 0;
   localparam int SB_ECC_HI   = 5;
   localparam int SB_ECC_LO   = 4;
   localparam int SB_BUSY     = 0;

   // serial framing
   localparam logic [2:0] BYTE_LAST_BIT = 3'h7;
   localparam logic [1:0] BI_OP   = 2'h0;
   localparam logic [1:0] BI_ADDR = 2'h1;
   localparam logic [1:0] BI_DATA = 2'h2;
   localparam logic [1:0] BI_MAX  = 2'h3;

   // page layout
   localparam logic [11:0] SPARE_BASE    = 12'h800;
   localparam logic [11:0] PARITY_LO     = 12'h840;
   localparam logic [11:0] PARITY_HI     = 12'h87f;
   localparam logic [11:0] BAD_MARK_ADDR = 12'h800;
   localparam int MAIN_SEG_HI = 10;
   localparam int MAIN_SEG_LO = 9;
   localparam int META_SEG_HI = 5;
   localparam int META_SEG_LO = 4;
   localparam logic [3:0] SEG_META0  = 4'h4;
   localparam logic [3:0] SEG_PARITY = 4'h8;
   localparam logic [3:0] SEG_NONE   = 4'hf;

   // correction status codes and reset values
   localparam logic [1:0] ES_CLEAN = 2'h0;
   localparam logic [1:0] ES_FIXED = 2'h1;
   localparam logic [1:0] ES_FAIL  = 2'h2;
   localparam logic [2:0] LOCK_RST = 3'h7;

   // timing
   localparam int CLK_PERIOD_NS        = 8;
   localparam int SLEEP_ENTRY_DELAY_NS = 3000;
   localparam int WAKE_DELAY_NS        = 3000;
   localparam int POWER_ON_WAIT_MS     = 2;
   localparam int SLEEP_ENTRY_CYC =
      (SLEEP_ENTRY_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int WAKE_CYC =
      (WAKE_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int POWER_ON_WAIT_CYC_DFLT =
      (POWER_ON_WAIT_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CNT_W = 18;

   typedef struct packed {
      logic       guard;
      logic [2:0] lock;
      logic       flip;
      logic       comp;
   } nld_prot_s;

   typedef struct packed {
      logic lockdown;
      logic ecc_on;
      logic qe;
   } nld_cfg_s;

   typedef enum logic [2:0] {
      PW_ACTIVE = 3'b000,
      PW_ENTER  = 3'b001,
      PW_SLEEP  = 3'b010,
      PW_WAKE   = 3'b011,
      PW_POR    = 3'b100
   } nld_pwr_e;

   typedef enum logic [2:0] {
      SQ_IDLE   = 3'b000,
      SQ_ENCODE = 3'b001,
      SQ_COMMIT = 3'b010,
      SQ_LOAD   = 3'b011,
      SQ_CHECK  = 3'b100
   } nld_seq_e;
endpackage

// File: logic/nld_core.sv
`timescale 1ns/1ps
module nld_core
   import nld_pkg::*;
#(
   parameter int POWER_ON_WAIT_CYC = POWER_ON_WAIT_CYC_DFLT
) (
   input  wire logic        i_clk_sys,
   input  wire logic        i_resetn,
   input  wire logic        i_spi_sclk,
   input  wire logic        i_spi_csn,
   input  wire logic        i_spi_mosi,
   output logic             o_spi_miso,
   output logic             o_spi_miso_oen,
   input  wire logic        i_array_busy,
   input  wire logic        i_prog_start,
   input  wire logic        i_read_start,
   input  wire logic        i_array_done,
   input  wire logic        i_ecc_done,
   input  wire logic        i_ecc_corrected,
   input  wire logic        i_ecc_fail,
   input  wire logic [11:0] i_cache_addr,
   output logic             o_cache_wr_allow,
   output logic [3:0]       o_seg_index,
   output logic             o_ecc_on,
   output logic             o_ecc_encode,
   output logic             o_ecc_check,
   output logic             o_array_commit,
   output logic             o_array_load,
   output logic             o_cache_out_ready,
   output logic [1:0]       o_ecc_status,
   output nld_prot_s        o_prot,
   output logic             o_lockdown,
   output logic             o_deep_sleep,
   output logic             o_standby,
   output logic             o_busy
);

   // segment of a cache byte address
   function automatic logic [3:0] seg_of(input logic [11:0] a);
      logic [3:0] s;
      s = SEG_NONE;
      if (a < SPARE_BASE) begin
         s = {2'h0, a[MAIN_SEG_HI:MAIN_SEG_LO]};
      end else if (a < PARITY_LO) begin
         s = SEG_META0 | {2'h0, a[META_SEG_HI:META_SEG_LO]};
      end else if (a <= PARITY_HI) begin
         s = SEG_PARITY;
      end
      return s;
   endfunction

   // readback value of one feature address
   function automatic logic [7:0] feat_val(
      input logic [7:0] a,
      input nld_prot_s  p,
      input nld_cfg_s   c,
      input logic [1:0] es,
      input logic       b
   );
      logic [7:0] v;
      v = 8'h00;
      if (a == FA_PROT) begin
         v[PB_GUARD]              = p.guard;
         v[PB_LOCK_HI:PB_LOCK_LO] = p.lock;
         v[PB_FLIP]               = p.flip;
         v[PB_COMP]               = p.comp;
      end else if (a == FA_CFG) begin
         v[CB_ECC]      = c.ecc_on;
         v[CB_LOCKDOWN] = c.lockdown;
         v[CB_QE]       = c.qe;
      end else if (a == FA_STAT) begin
         v[SB_ECC_HI:SB_ECC_LO] = es;
         v[SB_BUSY]             = b;
      end
      return v;
   endfunction

   logic [2:0]     sclk_q;
   logic [2:0]     csn_q;
   logic [1:0]     mosi_q;
   logic [7:0]     shift_q;
   logic [2:0]     bit_q;
   logic [1:0]     byte_q;
   logic [7:0]     op_q;
   logic [7:0]     addr_q;
   logic           arm_q;
   nld_pwr_e       pwr_q;
   nld_pwr_e       pwr_d;
   logic [CNT_W-1:0] cnt_q;
   logic [CNT_W-1:0] cnt_d;
   logic           sleep_q;
   nld_prot_s      prot_q;
   nld_cfg_s       cfg_q;
   nld_seq_e       seq_q;
   nld_seq_e       seq_d;
   logic [1:0]     ecc_stat_q;
   logic           ready_q;
   logic [7:0]     out_q;
   logic           drv_q;
   logic           miso_q;

   // pin synchronisers: stage 0 is read only by stage 1
   always_ff @(posedge i_clk_sys) begin
      if (!i_resetn) begin
         sclk_q <= 3'h0;
         csn_q  <= 3'h7;
         mosi_q <= 2'h0;
      end else begin
         sclk_q <= {sclk_q[1:0], i_spi_sclk};
         csn_q  <= {csn_q[1:0], i_spi_csn};
         mosi_q <= {mosi_q[0], i_spi_mosi};
      end
   end

   wire sclk_rise = sclk_q[1] & ~sclk_q[2];
   wire sclk_fall = ~sclk_q[1] & sclk_q[2];
   wire cs_rise   = csn_q[1] & ~csn_q[2];
   wire cs_fall   = ~csn_q[1] & csn_q[2];
   wire selected  = ~csn_q[1];
   wire [7:0] byte_in = {shift_q[6:0], mosi_q[1]};
   wire byte_done = sclk_rise & selected & (bit_q == BYTE_LAST_BIT);

   // bit and byte counting within one select frame
   always_ff @(posedge i_clk_sys) begin
      if (!i_resetn || cs_fall) begin
         bit_q   <= 3'h0;
         byte_q  <= BI_OP;
         shift_q <= 8'h00;
      end else if (sclk_rise && selected) begin
         shift_q <= byte_in;
         bit_q   <= bit_q + 3'h1;
         if (bit_q == BYTE_LAST_BIT && byte_q != BI_MAX) begin
            byte_q <= byte_q + 2'h1;
         end
      end
   end

   // opcode and feature address capture
   always_ff @(posedge i_clk_sys) begin
      if (!i_resetn) begin
         op_q   <= 8'h00;
         addr_q <= 8'h00;
      end else if (byte_done && byte_q == BI_OP) begin
         op_q <= byte_in;
      end else if (byte_done && byte_q == BI_ADDR) begin
         addr_q <= byte_in;
      end
   end

   // a one-byte command counts only if select rises on a byte boundary
   wire single_ok = cs_rise & (byte_q == BI_ADDR) & (bit_q == '0);
   wire do_sleep   = single_ok & (op_q == OP_SLEEP);
   wire do_release = single_ok & (op_q == OP_RELEASE);
   wire do_soft    = single_ok & (op_q == OP_SOFT_RST);
   wire do_rst_en  = single_ok & (op_q == OP_RST_EN);
   wire do_rst     = single_ok & (op_q == OP_RST) & arm_q;
   wire live       = (pwr_q == PW_ACTIVE) | (pwr_q == PW_SLEEP);
   wire rst_go     = do_rst & live;
   wire op_busy    = i_array_busy | (seq_q != SQ_IDLE);

   // reset enable must be the command just before reset
   always_ff @(posedge i_clk_sys) begin
      if (!i_resetn) begin
         arm_q <= 1'b0;
      end else if (cs_rise) begin
         arm_q <= do_rst_en & live;
      end
   end

   // power state sequencing; entry, wake and reset delays share one counter
   always_comb begin
      pwr_d = pwr_q;
      cnt_d = (cnt_q != '0) ? cnt_q - 1'b1 : cnt_q;
      case (pwr_q)
         PW_ACTIVE: begin
            if (rst_go) begin
               pwr_d = PW_POR;
               cnt_d = CNT_W'(POWER_ON_WAIT_CYC - 1);
            end else if (do_sleep && !op_busy) begin
               pwr_d = PW_ENTER;
               cnt_d = CNT_W'(SLEEP_ENTRY_CYC - 1);
            end
         end
         PW_ENTER: begin
            if (cnt_q == '0) begin
               pwr_d = PW_SLEEP;
            end
         end
         PW_SLEEP: begin
            // everything else is dropped while asleep
            if (rst_go) begin
               pwr_d = PW_POR;
               cnt_d = CNT_W'(POWER_ON_WAIT_CYC - 1);
            end else if ((do_release && !op_busy) || do_soft) begin
               pwr_d = PW_WAKE;
               cnt_d = CNT_W'(WAKE_CYC - 1);
            end
         end
         PW_WAKE, PW_POR: begin
            if (cnt_q == '0) begin
               pwr_d = PW_ACTIVE;
            end
         end
         default: begin
            pwr_d = PW_ACTIVE;
         end
      endcase
   end

   // power-up always lands in the active, non-sleeping state
   always_ff @(posedge i_clk_sys) begin
      if (!i_resetn) begin
         pwr_q   <= PW_ACTIVE;
         cnt_q   <= '0;
         sleep_q <= 1'b0;
      end else begin
         pwr_q   <= pwr_d;
         cnt_q   <= cnt_d;
         sleep_q <= (pwr_d == PW_SLEEP);
      end
   end

   // feature writes are taken only when fully awake
   wire feat_wr = byte_done & (byte_q == BI_DATA) & (op_q == OP_FEAT_WR)
                  & (pwr_q == PW_ACTIVE);
   wire wr_prot = feat_wr & (addr_q == FA_PROT) & ~cfg_q.lockdown;
   wire wr_cfg  = feat_wr & (addr_q == FA_CFG);
   wire por_start = (pwr_q != PW_POR) & (pwr_d == PW_POR);

   // protection field; reset pair restores the default unless frozen
   always_ff @(posedge i_clk_sys) begin
      if (!i_resetn || (por_start && !cfg_q.lockdown)) begin
         prot_q <= '{guard: 1'b0, lock: LOCK_RST, flip: 1'b0, comp: 1'b0};
      end else if (wr_prot) begin
         prot_q.guard <= byte_in[PB_GUARD];
         prot_q.lock  <= byte_in[PB_LOCK_HI:PB_LOCK_LO];
         prot_q.flip  <= byte_in[PB_FLIP];
         prot_q.comp  <= byte_in[PB_COMP];
      end
   end

   // configuration; correction-on defaults high, one driver for the struct
   // lockdown survives the reset pair too: only power removal clears it
   always_ff @(posedge i_clk_sys) begin
      if (!i_resetn) begin
         cfg_q <= '{lockdown: 1'b0, ecc_on: 1'b1, qe: 1'b0};
      end else begin
         if (por_start) begin
            cfg_q.ecc_on <= 1'b1;
            cfg_q.qe     <= 1'b0;
         end else if (wr_cfg) begin
            cfg_q.ecc_on <= byte_in[CB_ECC];
            cfg_q.qe     <= byte_in[CB_QE];
         end
         if (wr_cfg && byte_in[CB_LOCKDOWN]) begin
            cfg_q.lockdown <= 1'b1;
         end
      end
   end

   // page sequencer around the correction engine
   always_comb begin
      seq_d = seq_q;
      case (seq_q)
         SQ_IDLE: begin
            if (i_prog_start) begin
               seq_d = cfg_q.ecc_on ? SQ_ENCODE : SQ_COMMIT;
            end else if (i_read_start) begin
               seq_d = SQ_LOAD;
            end
         end
         SQ_ENCODE: begin
            if (i_ecc_done) begin
               seq_d = SQ_COMMIT;
            end
         end
         SQ_COMMIT: begin
            if (i_array_done) begin
               seq_d = SQ_IDLE;
            end
         end
         SQ_LOAD: begin
            if (i_array_done) begin
               seq_d = cfg_q.ecc_on ? SQ_CHECK : SQ_IDLE;
            end
         end
         SQ_CHECK: begin
            if (i_ecc_done) begin
               seq_d = SQ_IDLE;
            end
         end
         default: begin
            seq_d = SQ_IDLE;
         end
      endcase
   end

   wire check_end = (seq_q == SQ_CHECK) & i_ecc_done;
   wire load_end  = (seq_q == SQ_LOAD) & i_array_done & ~cfg_q.ecc_on;
   wire [1:0] stat_new = i_ecc_fail ? ES_FAIL :
                         (i_ecc_corrected ? ES_FIXED : ES_CLEAN);

   // cache output is held back until the check ends, or until the load ends when correction is off
   always_ff @(posedge i_clk_sys) begin
      if (!i_resetn || por_start) begin
         seq_q      <= SQ_IDLE;
         ecc_stat_q <= ES_CLEAN;
         ready_q    <= 1'b0;
      end else begin
         seq_q <= seq_d;
         if (check_end) begin
            ecc_stat_q <= stat_new;
         end
         if (check_end || load_end) begin
            ready_q <= 1'b1;
         end else if (seq_q == SQ_IDLE && i_read_start) begin
            ready_q <= 1'b0;
         end
      end
   end

   // feature read: value loaded after address, shifted on falling edges
   wire rd_load = byte_done & (byte_q == BI_ADDR) & (op_q == OP_FEAT_RD)
                  & (pwr_q != PW_SLEEP) & (pwr_q != PW_ENTER);
   always_ff @(posedge i_clk_sys) begin
      if (!i_resetn || cs_rise) begin
         out_q  <= 8'h00;
         drv_q  <= 1'b0;
         miso_q <= 1'b0;
      end else if (rd_load) begin
         out_q <= feat_val(byte_in, prot_q, cfg_q, ecc_stat_q, o_busy);
         drv_q <= 1'b1;
      end else if (sclk_fall && drv_q) begin
         miso_q <= out_q[7];
         out_q  <= {out_q[6:0], out_q[7]};
      end
   end

   // parity bytes are host-locked only while correcting
   wire in_parity = (i_cache_addr >= PARITY_LO) & (i_cache_addr <= PARITY_HI);
   assign o_cache_wr_allow  = ~(cfg_q.ecc_on & in_parity);
   assign o_seg_index       = seg_of(i_cache_addr);
   assign o_ecc_on          = cfg_q.ecc_on;
   assign o_ecc_encode      = (seq_q == SQ_ENCODE);
   assign o_ecc_check       = (seq_q == SQ_CHECK);
   assign o_array_commit    = (seq_q == SQ_COMMIT);
   assign o_array_load      = (seq_q == SQ_LOAD);
   assign o_cache_out_ready = ready_q;
   assign o_ecc_status      = ecc_stat_q;
   assign o_prot            = prot_q;
   assign o_lockdown        = cfg_q.lockdown;
   assign o_deep_sleep      = sleep_q;
   assign o_busy = op_busy | (pwr_q == PW_WAKE) | (pwr_q == PW_POR)
                   | (pwr_q == PW_ENTER);
   // deselect alone gives standby only when nothing runs
   assign o_standby = csn_q[1] & ~o_busy & (pwr_q == PW_ACTIVE);
   assign o_spi_miso     = miso_q;
   assign o_spi_miso_oen = ~drv_q;

   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (!i_resetn);

   a_lockdown_sticky: assert property (
      cfg_q.lockdown |=> cfg_q.lockdown)
      else $error("lockdown cleared");
   a_prot_frozen: assert property (
      cfg_q.lockdown |=> $stable(prot_q))
      else $error("protection changed under lockdown");
   a_lockdown_set: assert property (
      wr_cfg && byte_in[CB_LOCKDOWN] |=> o_lockdown)
      else $error("lockdown not engaged");
   a_ecc_power_up: assert property (
      $rose(i_resetn) |-> o_ecc_on)
      else $error("correction off after power-up");
   a_ecc_write: assert property (
      wr_cfg && !por_start |=> o_ecc_on == $past(byte_in[CB_ECC]))
      else $error("correction bit not written");
   a_prog_encode: assert property (
      seq_q == SQ_IDLE && i_prog_start && cfg_q.ecc_on && !por_start
      |=> o_ecc_encode && !o_array_commit)
      else $error("commit before parity");
   a_read_check: assert property (
      seq_q == SQ_LOAD && i_array_done && cfg_q.ecc_on && !por_start
      |=> o_ecc_check && !o_cache_out_ready)
      else $error("read not checked");
   a_status_upd: assert property (
      check_end && !por_start
      |=> o_ecc_status == $past(stat_new) && o_cache_out_ready)
      else $error("status not updated");
   a_parity_block: assert property (
      o_ecc_on && in_parity
      |-> !o_cache_wr_allow && o_seg_index == SEG_PARITY)
      else $error("parity write allowed");
   a_open_page: assert property (
      !o_ecc_on |-> o_cache_wr_allow)
      else $error("page not open");
   a_sleep_reject: assert property (
      pwr_q == PW_ACTIVE && do_sleep && op_busy && !rst_go
      |=> pwr_q == PW_ACTIVE)
      else $error("sleep accepted while busy");
   a_sleep_entry: assert property (
      pwr_q == PW_ENTER && cnt_q == '0
      |=> o_deep_sleep && pwr_q == PW_SLEEP)
      else $error("sleep entry late");
   a_sleep_ignore: assert property (
      pwr_q == PW_SLEEP && !rst_go && !do_soft && !(do_release && !op_busy)
      |=> o_deep_sleep)
      else $error("sleep left by other command");
   a_release_busy: assert property (
      pwr_q == PW_SLEEP && do_release && op_busy && !rst_go && !do_soft
      |=> pwr_q == PW_SLEEP)
      else $error("release taken while busy");
   a_wake_hold: assert property (
      pwr_q == PW_WAKE && cnt_q != '0 |=> pwr_q == PW_WAKE && o_busy)
      else $error("wake ended early");
   a_power_up_standby: assert property (
      $rose(i_resetn) |-> pwr_q == PW_ACTIVE && !o_deep_sleep)
      else $error("sleep persisted");

   c_sleep: cover property (pwr_q == PW_SLEEP ##1 pwr_q == PW_WAKE);
   c_reset_pair: cover property (pwr_q == PW_POR ##1 pwr_q == PW_ACTIVE);
   c_ecc_fail: cover property (check_end && i_ecc_fail);
   c_lockdown: cover property ($rose(cfg_q.lockdown));
endmodule

// File: dv/nld_host_model.sv
`timescale 1ns/1ps
module nld_host_model (
   output logic o_sclk,
   output logic o_csn,
   output logic o_mosi
);
   // idle bus: select high, clock parked low
   initial begin
      o_sclk = 1'b0;
      o_csn  = 1'b1;
      o_mosi = 1'b0;
   end

   // mode 0 frame, msb first, whole bytes only
   // spare byte 800h never carries host metadata here
   task automatic xfer(input logic [23:0] v, input int nbytes);
      int i;
      o_csn = 1'b0;
      for (i = 23; i >= 24 - 8 * nbytes; i--) begin
         o_mosi = v[i];
         #32 o_sclk = 1'b1;
         #32 o_sclk = 1'b0;
      end
      #32 o_csn = 1'b1;
      o_mosi = ~o_mosi;  // released line has no pull, so show garbage
      #104;              // select held high between frames
      // 104 keeps the next frame off the sampling edge of the system clock
   endtask
endmodule

// File: dv/tb.sv
`timescale 1ns/1ps
module tb;
   import nld_pkg::*;
   logic i_clk_sys, i_resetn, i_array_busy, i_prog_start, i_read_start;
   logic i_array_done, i_ecc_done, i_ecc_corrected, i_ecc_fail;
   logic [11:0] i_cache_addr;
   logic sclk, csn, mosi, miso, oen, wr_allow, ecc_on, enc, chk_on;
   logic commit, load, ready, lockdown, sleep, standby, busy;
   logic [3:0] seg;
   logic [1:0] status;
   logic [7:0] rx;
   logic       rx_oen;
   nld_prot_s prot;
   int n_errors, n_compared, k;
   logic [11:0] seg_a [7] = '{12'h000, 12'h3ff, 12'h600, 12'h80f,
                              12'h83f, 12'h840, 12'h880};
   logic [3:0]  seg_e [7] = '{4'h0, 4'h1, 4'h3, 4'h4, 4'h7, 4'h8, 4'hf};

   nld_host_model host_u (.o_sclk(sclk), .o_csn(csn), .o_mosi(mosi));
   nld_core #(.POWER_ON_WAIT_CYC(64)) dut_u (
      .i_clk_sys(i_clk_sys), .i_resetn(i_resetn), .i_spi_sclk(sclk),
      .i_spi_csn(csn), .i_spi_mosi(mosi), .o_spi_miso(miso),
      .o_spi_miso_oen(oen), .i_array_busy(i_array_busy),
      .i_prog_start(i_prog_start), .i_read_start(i_read_start),
      .i_array_done(i_array_done), .i_ecc_done(i_ecc_done),
      .i_ecc_corrected(i_ecc_corrected), .i_ecc_fail(i_ecc_fail),
      .i_cache_addr(i_cache_addr), .o_cache_wr_allow(wr_allow),
      .o_seg_index(seg), .o_ecc_on(ecc_on), .o_ecc_encode(enc),
      .o_ecc_check(chk_on), .o_array_commit(commit), .o_array_load(load),
      .o_cache_out_ready(ready), .o_ecc_status(status), .o_prot(prot),
      .o_lockdown(lockdown), .o_deep_sleep(sleep), .o_standby(standby),
      .o_busy(busy));

   // free running system clock
   initial i_clk_sys = 1'b0;
   always #4 i_clk_sys = ~i_clk_sys;

   // host side of a read: data line and enable taken on link clock rise
   always @(posedge sclk) begin
      rx     <= {rx[6:0], miso};
      rx_oen <= oen;
   end

   task automatic chk(input logic [11:0] got, input logic [11:0] exp);
      n_compared++;
      if (got !== exp) begin
         n_errors++;
         $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(negedge i_clk_sys);
   endtask

   // feature write: opcode, address, data in one frame
   task automatic fwr(input logic [7:0] a, input logic [7:0] d);
      host_u.xfer({OP_FEAT_WR, a, d}, 3);
   endtask

   task automatic op(input logic [7:0] o);
      host_u.xfer({o, 16'h0000}, 1);
   endtask

   task report_and_stop;
      $display("errors %0d compared %0d", n_errors, n_compared);
      if (n_errors == 0 && n_compared > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   // guards against a hung handshake
   initial begin
      #400000;
      $display("ERROR at %0t: watchdog expired", $time);
      n_errors++;
      report_and_stop;
   end

   initial begin
      {i_array_busy, i_prog_start, i_read_start, i_array_done} = 4'h0;
      {i_ecc_done, i_ecc_corrected, i_ecc_fail} = 3'h0;
      i_cache_addr = 12'h000;
      i_resetn = 1'b0;
      cyc(3);
      i_resetn = 1'b1;
      cyc(4);
      chk(12'(ecc_on), 12'h001);
      chk(12'(sleep), 12'h000);
      chk(12'(prot), 12'h01c);
      // correction off opens the parity bytes, on closes them
      fwr(FA_CFG, 8'h00);
      cyc(2);
      chk(12'(ecc_on), 12'h000);
      i_cache_addr = 12'h840;
      cyc(1);
      chk(12'(wr_allow), 12'h001);
      fwr(FA_CFG, 8'h10);
      cyc(2);
      chk(12'(wr_allow), 12'h000);
      i_cache_addr = 12'h87f;
      cyc(1);
      chk(12'(wr_allow), 12'h000);
      i_cache_addr = 12'h83f;
      cyc(1);
      chk(12'(wr_allow), 12'h001);
      for (k = 0; k < 7; k++) begin
         i_cache_addr = seg_a[k];
         cyc(1);
         chk(12'(seg), 12'(seg_e[k]));
      end
      // checked read with a corrected error, then a program
      i_read_start = 1'b1;
      cyc(1);
      i_read_start = 1'b0;
      cyc(1);
      chk(12'({load, ready}), 12'h002);
      i_array_done = 1'b1;
      cyc(1);
      i_array_done = 1'b0;
      cyc(1);
      chk(12'({chk_on, ready}), 12'h002);
      i_ecc_corrected = 1'b1;
      i_ecc_done = 1'b1;
      cyc(1);
      i_ecc_done = 1'b0;
      cyc(2);
      chk(12'({status, ready}), 12'h003);
      i_prog_start = 1'b1;
      cyc(1);
      i_prog_start = 1'b0;
      cyc(2);
      chk(12'({enc, commit}), 12'h002);
      i_ecc_done = 1'b1;
      cyc(1);
      i_ecc_done = 1'b0;
      cyc(2);
      chk(12'({enc, commit}), 12'h001);
      i_array_done = 1'b1;
      cyc(1);
      i_array_done = 1'b0;
      cyc(2);
      // a failed check reports the fail code
      i_ecc_fail = 1'b1;
      i_read_start = 1'b1;
      cyc(1);
      i_read_start = 1'b0;
      i_array_done = 1'b1;
      cyc(1);
      i_array_done = 1'b0;
      i_ecc_done = 1'b1;
      cyc(1);
      i_ecc_done = 1'b0;
      cyc(1);
      chk(12'({status, ready}), 12'h005);
      i_ecc_fail = 1'b0;
      // lockdown freezes the protection field
      fwr(FA_PROT, 8'h00);
      fwr(FA_CFG, 8'h12);
      cyc(2);
      chk(12'({lockdown, prot}), 12'h040);
      fwr(FA_PROT, 8'hbe);
      fwr(FA_CFG, 8'h10);
      cyc(2);
      chk(12'({lockdown, prot}), 12'h040);
      // extra bits after sleep, then sleep while array busy
      host_u.xfer({OP_SLEEP, 16'h0000}, 2);
      cyc(400);
      chk(12'({sleep, standby}), 12'h001);
      i_array_busy = 1'b1;
      op(OP_SLEEP);
      cyc(400);
      chk(12'(sleep), 12'h000);
      i_array_busy = 1'b0;
      // proper sleep, ignored write, release while busy, real release
      op(OP_SLEEP);
      chk(12'(sleep), 12'h000);
      cyc(400);
      chk(12'(sleep), 12'h001);
      fwr(FA_CFG, 8'h00);
      chk(12'(ecc_on), 12'h001);
      i_array_busy = 1'b1;
      op(OP_RELEASE);
      chk(12'(sleep), 12'h001);
      i_array_busy = 1'b0;
      op(OP_RELEASE);
      chk(12'({sleep, busy}), 12'h001);
      cyc(400);
      chk(12'(busy), 12'h000);
      // status poll once awake: fail code from the last check, not busy
      host_u.xfer({OP_FEAT_RD, FA_STAT, 8'h00}, 3);
      chk(12'({rx_oen, rx}), 12'h020);
      chk(12'(oen), 12'h001);
      // reset pair restores correction-on but keeps lockdown and the frozen protection field
      fwr(FA_CFG, 8'h00);
      op(OP_SLEEP);
      cyc(400);
      op(OP_RST_EN);
      op(OP_RST);
      chk(12'(sleep), 12'h000);
      cyc(100);
      chk(12'({busy, ecc_on, lockdown}), 12'h003);
      chk(12'(prot), 12'h000);
      // soft reset also leaves deep sleep
      op(OP_SLEEP);
      cyc(400);
      op(OP_SOFT_RST);
      cyc(400);
      chk(12'({sleep, busy}), 12'h000);
      // only a power cycle drops lockdown
      i_resetn = 1'b0;
      cyc(3);
      i_resetn = 1'b1;
      cyc(2);
      chk(12'({lockdown, sleep}), 12'h000);
      chk(12'(prot), 12'h01c);
      report_and_stop;
   end
endmodule
